/* File: hw/clock_output_stage_pkg.sv */
// Constants shared by the clock output stage: register map, field layout,
// reset values and the driver codes.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`default_nettype none
package clock_output_stage_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_DIV        = 8'h00;
    localparam logic [7:0]  OFF_EN         = 8'h04;
    localparam logic [7:0]  OFF_MODE       = 8'h08;
    localparam logic [7:0]  OFF_AMP        = 8'h0C;
    localparam logic [7:0]  OFF_STATUS     = 8'h10;
    localparam logic [7:0]  ADDR_NONE      = 8'hFF;  // Never mapped
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;

    // ------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------
    localparam logic [15:0] DIV_RST        = 16'h8069;
    localparam logic [15:0] DIV_WMASK      = 16'hBFFF;
    localparam logic [7:0]  EN_RST         = 8'h00;
    localparam logic [7:0]  EN_WMASK       = 8'h0F;
    localparam logic [7:0]  MODE_RST       = 8'h6C;
    localparam logic [7:0]  AMP_RST        = 8'hB4;
    localparam logic [7:0]  AMP_WMASK      = 8'hFF;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          RATIO_WIDTH    = 14;
    localparam int          RATIO_MIN      = 10;
    localparam int          DIV_REG_ON_BIT = 15;
    localparam int          DIV_RSVD_BIT   = 14;
    localparam int          EN_PD_BIT      = 0;
    localparam int          EN_DIS_BIT     = 1;
    localparam int          EN_STATE_LSB   = 2;
    localparam int          MODE_TYPE_LSB  = 0;
    localparam int          MODE_BIAS_BIT  = 2;
    localparam int          MODE_TERM_BIT  = 3;
    localparam int          MODE_CM_LSB    = 4;
    localparam int          MODE_CMOS_LSB  = 6;
    localparam int          AMP_RSVD_LSB   = 0;
    localparam int          AMP_LVDS_BIT   = 3;
    localparam int          AMP_SWING_LSB  = 4;
    localparam int          STS_ACTIVE_BIT = 0;
    localparam int          STS_DIVCLK_BIT = 1;
    localparam int          STS_PIN_BIT    = 2;

    // ------------------------------------------------------------
    // Driver codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DRV_HCSL = 2'h0, DRV_RSVD = 2'h1, DRV_LVDS = 2'h2, DRV_CMOS = 2'h3
    } drv_type_t;
    typedef enum logic [1:0] {
        DIS_LOW = 2'h0, DIS_LOW_HIGH = 2'h1, DIS_FLOAT = 2'h2, DIS_RUN = 2'h3
    } dis_state_t;
    typedef enum logic [1:0] {
        CMOS_SAME = 2'h0, CMOS_OPP = 2'h1, CMOS_TRUE_ONLY = 2'h2, CMOS_COMP_ONLY = 2'h3
    } cmos_mode_t;

endpackage
`default_nettype wire

/* File: hw/drv_ctrl_if.sv */
// Control bundle between the register file, the divider and the pin driver.
// Assumes all members change on mclk_i only.
`default_nettype none
interface drv_ctrl_if;
    import clock_output_stage_pkg::*;
    logic       pd;
    logic       disabled;
    logic       div_clk;
    dis_state_t dis_state;
    drv_type_t  mode;
    cmos_mode_t cmos_mode;
    modport src (output div_clk);
    modport drv (input pd, disabled, div_clk, dis_state, mode, cmos_mode);
endinterface
`default_nettype wire

/* File: hw/output_ratio_divider.sv */
// Integer output divider: one period of div_clk every ratio cycles of mclk_i.
// Assumes ratio_i and on_i are register outputs on mclk_i.
`default_nettype none
module output_ratio_divider
    import clock_output_stage_pkg::*;
#(
    parameter int RATIO_W = RATIO_WIDTH
) (
    // Clock and reset
    input  wire logic               mclk_i,
    input  wire logic               srst_i,
    // Control
    input  wire logic [RATIO_W-1:0] ratio_i,
    input  wire logic               on_i,
    drv_ctrl_if.src                 ctl
);
    if (RATIO_W < 4 || RATIO_W > 15) begin : g_chk
        $error("RATIO_W out of range");
    end

    logic [RATIO_W-1:0] cnt_q;
    logic [RATIO_W-1:0] cnt_d;
    logic [RATIO_W-1:0] ratio_q;
    logic [RATIO_W-1:0] ratio_d;
    logic               clk_q;
    logic               clk_d;
    logic               wrap;

    // New ratio only at the period boundary, so no runt pulse on a change
    always_comb begin
        wrap    = cnt_q >= ratio_q - RATIO_W'(1);
        ratio_d = ratio_q;
        cnt_d   = cnt_q + RATIO_W'(1);
        if (!on_i || wrap) begin
            cnt_d   = '0;
            ratio_d = ratio_i;
        end
        clk_d = on_i && (cnt_d < (ratio_d >> 1));
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cnt_q   <= '0;
            ratio_q <= RATIO_W'(DIV_RST);
            clk_q   <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            ratio_q <= ratio_d;
            clk_q   <= clk_d;
        end
    end

    assign ctl.div_clk = clk_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    a_period_wrap: assert property (on_i && wrap |=> cnt_q == '0)
        else $error("divider did not wrap at period end");
    a_ratio_stable: assert property (on_i && !wrap |=> $stable(ratio_q))
        else $error("ratio changed inside a period");
    a_regulator_off: assert property (!on_i |=> !clk_q && cnt_q == '0)
        else $error("divider runs with regulator off");
endmodule
`default_nettype wire

/* File: hw/clock_pin_driver.sv */
// Output pin stage: maps the divided clock onto the true and complement pins
// by driver type, CMOS phasing, disable state and power-down.
// Assumes all controls are synchronous to mclk_i.
`default_nettype none
module clock_pin_driver
    import clock_output_stage_pkg::*;
(
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic srst_i,
    // Controls
    drv_ctrl_if.drv   ctl,
    // Pins
    output logic      true_o,
    output logic      true_oe_n_o,
    output logic      comp_o,
    output logic      comp_oe_n_o
);
    logic t_d;
    logic c_d;
    logic tz_d;
    logic cz_d;

    // Power-down outranks every enable or disable source
    always_comb begin
        t_d  = ctl.div_clk;
        c_d  = ~ctl.div_clk;
        tz_d = 1'b0;
        cz_d = 1'b0;
        if (ctl.mode == DRV_CMOS) begin
            case (ctl.cmos_mode)
                CMOS_SAME:      c_d = ctl.div_clk;
                CMOS_TRUE_ONLY: c_d = 1'b0;
                CMOS_COMP_ONLY: begin
                    t_d = 1'b0;
                    c_d = ctl.div_clk;
                end
                default: ;
            endcase
        end
        if (ctl.pd) begin
            t_d  = 1'b0;
            c_d  = 1'b0;
            tz_d = 1'b1;
            cz_d = 1'b1;
        end else if (ctl.disabled) begin
            case (ctl.dis_state)
                DIS_LOW: begin
                    t_d = 1'b0;
                    c_d = (ctl.mode == DRV_LVDS);
                end
                DIS_LOW_HIGH: begin
                    t_d = 1'b0;
                    c_d = 1'b1;
                end
                DIS_FLOAT: begin
                    t_d  = 1'b0;
                    c_d  = 1'b0;
                    tz_d = 1'b1;
                    cz_d = 1'b1;
                end
                default: ;  // Debug: keep toggling
            endcase
        end
    end

    // Pins float during reset
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            true_o      <= 1'b0;
            comp_o      <= 1'b0;
            true_oe_n_o <= 1'b1;
            comp_oe_n_o <= 1'b1;
        end else begin
            true_o      <= t_d;
            comp_o      <= c_d;
            true_oe_n_o <= tz_d;
            comp_oe_n_o <= cz_d;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    sequence s_held_off;
        !ctl.pd && ctl.disabled;
    endsequence
    sequence s_running;
        !ctl.pd && !ctl.disabled;
    endsequence

    a_pd_tristate: assert property (ctl.pd |=> true_oe_n_o && comp_oe_n_o)
        else $error("pins not floated in power-down");
    a_dis_low_high: assert property (
        s_held_off ##0 ctl.dis_state == DIS_LOW_HIGH |=> !true_o && comp_o && !true_oe_n_o)
        else $error("disabled low/high state wrong");
    a_cmos_opposite: assert property (
        s_running ##0 (ctl.mode == DRV_CMOS && ctl.cmos_mode == CMOS_OPP)
        |=> true_o != comp_o)
        else $error("CMOS pins not in opposite phase");
endmodule
`default_nettype wire

/* File: hw/clock_output_stage_control.sv */
// Clock output stage: AHB-Lite register file, output divider and pin driver.
// Assumes one clock mclk_i, a synchronous reset and a single AHB-Lite master.
// Contract
// - Divider divides by the 14-bit ratio; software never programs below ten.
// - Regulator enable, reset one, keeps the divider regulator powered.
// - Disabled state code fixes pins: low/low, low/high, float, or toggling; in LVDS the low/low code drives low/high.
// - Software disable bit forces the driver disabled; the enable pin also disables.
// - Power-down tri-states both pins and overrides all enable controls.
// - Driver type code: 0 HCSL, 2 LVDS, 3 CMOS, 1 reserved.
// - CMOS phasing: same, opposite, true only, complement only.
// - LVDS common-mode code, 700mV to 1000mV, resets to code two.
// - Termination bit, set at reset, connects the internal HCSL termination.
// - Bias enable bit, set at reset, turns the driver bias on.
// - LVDS amplitude bit selects 350mV or 400mV.
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`default_nettype none
module clock_output_stage_control
    import clock_output_stage_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Output enable pin, asynchronous, high enables
    input  wire logic        out_enable_pin_i,
    // Clock pins
    output logic             true_clock_pin_o,
    output logic             true_clock_pin_oe_n_o,
    output logic             complement_clock_pin_o,
    output logic             complement_clock_pin_oe_n_o,
    // Analog controls
    output logic             divider_regulator_on_o,
    output logic             driver_power_down_o,
    output logic             driver_bias_on_o,
    output logic             hcsl_term_on_o,
    output logic      [1:0]  driver_type_o,
    output logic      [1:0]  lvds_common_level_o,
    output logic      [3:0]  hcsl_swing_o,
    output logic             lvds_amp_high_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic [7:0]  en_q;
    logic [7:0]  en_d;
    logic [7:0]  mode_q;
    logic [7:0]  mode_d;
    logic [7:0]  amp_q;
    logic [7:0]  amp_d;
    logic        wr_q;
    logic        wr_d;
    logic [7:0]  addr_q;
    logic [7:0]  addr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        take;
    logic        pin_meta_q;
    logic        pin_meta_d;
    logic        pin_sync_q;
    logic        pin_sync_d;
    logic [2:0]  status;

    drv_ctrl_if ctl ();

    // Maps a bus address to a local offset; anything outside the page is unmapped
    function automatic logic [7:0] local_offset(input logic [31:0] addr);
        return (addr[31:8] == 24'h0) ? addr[7:0] : ADDR_NONE;
    endfunction

    // ------------------------------------------------------------
    // Bus address phase
    // ------------------------------------------------------------
    // Zero wait states: every transfer is taken at once and answered OKAY.
    // Read data is formed from the next-state values, so a read right after
    // a write to the same register returns the new value.
    always_comb begin
        take    = hsel_i && htrans_i[1] && hready_i;
        wr_d    = take && hwrite_i && (hsize_i == HSIZE_WORD);
        addr_d  = take ? local_offset(haddr_i) : ADDR_NONE;
        rdata_d = rdata_q;
        if (take && !hwrite_i) begin
            case (addr_d)
                OFF_DIV:    rdata_d = {16'h0, div_d};
                OFF_EN:     rdata_d = {24'h0, en_d};
                OFF_MODE:   rdata_d = {24'h0, mode_d};
                OFF_AMP:    rdata_d = {24'h0, amp_d};
                OFF_STATUS: rdata_d = {29'h0, status};
                default:    rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wr_q        <= 1'b0;
            addr_q      <= ADDR_NONE;
            rdata_q     <= 32'h0;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            wr_q        <= wr_d;
            addr_q      <= addr_d;
            rdata_q     <= rdata_d;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    assign hrdata_o = rdata_q;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Writes land in the data phase; masks keep read-only reserved bits at zero
    always_comb begin
        div_d  = div_q;
        en_d   = en_q;
        mode_d = mode_q;
        amp_d  = amp_q;
        if (wr_q) begin
            case (addr_q)
                OFF_DIV:  div_d  = hwdata_i[15:0] & DIV_WMASK;
                OFF_EN:   en_d   = hwdata_i[7:0] & EN_WMASK;
                OFF_MODE: mode_d = hwdata_i[7:0];
                OFF_AMP:  amp_d  = hwdata_i[7:0] & AMP_WMASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            div_q  <= DIV_RST;
            en_q   <= EN_RST;
            mode_q <= MODE_RST;
            amp_q  <= AMP_RST;
        end else begin
            div_q  <= div_d;
            en_q   <= en_d;
            mode_q <= mode_d;
            amp_q  <= amp_d;
        end
    end

    // ------------------------------------------------------------
    // Enable pin synchroniser
    // ------------------------------------------------------------
    // Two stages before anything looks at the pin
    always_comb begin
        pin_meta_d = out_enable_pin_i;
        pin_sync_d = pin_meta_q;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
        end
    end

    // ------------------------------------------------------------
    // Driver controls
    // ------------------------------------------------------------
    // A low enable pin disables the driver just like the software bit
    assign ctl.pd        = en_q[EN_PD_BIT];
    assign ctl.disabled  = en_q[EN_DIS_BIT] || !pin_sync_q;
    assign ctl.dis_state = dis_state_t'(en_q[EN_STATE_LSB +: 2]);
    assign ctl.mode      = drv_type_t'(mode_q[MODE_TYPE_LSB +: 2]);
    assign ctl.cmos_mode = cmos_mode_t'(mode_q[MODE_CMOS_LSB +: 2]);

    // Status shows the live driver state, divided clock level and pin level
    assign status[STS_ACTIVE_BIT] = !ctl.pd && !ctl.disabled;
    assign status[STS_DIVCLK_BIT] = ctl.div_clk;
    assign status[STS_PIN_BIT]    = pin_sync_q;

    // Analog controls come straight from register bits
    assign divider_regulator_on_o = div_q[DIV_REG_ON_BIT];
    assign driver_power_down_o    = en_q[EN_PD_BIT];
    assign driver_bias_on_o       = mode_q[MODE_BIAS_BIT];
    assign hcsl_term_on_o         = mode_q[MODE_TERM_BIT];
    assign driver_type_o          = mode_q[MODE_TYPE_LSB +: 2];
    assign lvds_common_level_o    = mode_q[MODE_CM_LSB +: 2];
    assign hcsl_swing_o           = amp_q[AMP_SWING_LSB +: 4];
    assign lvds_amp_high_o        = amp_q[AMP_LVDS_BIT];

    // ------------------------------------------------------------
    // Divider and pin stage
    // ------------------------------------------------------------
    // The divider resets its count whenever the regulator is off, so the
    // first period after power-up starts at count zero, but its high phase is one cycle short.
    output_ratio_divider #(
        .RATIO_W (RATIO_WIDTH)
    ) u_divider (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .ratio_i (div_q[RATIO_WIDTH-1:0]),
        .on_i    (div_q[DIV_REG_ON_BIT]),
        .ctl     (ctl.src)
    );

    clock_pin_driver u_pins (
        .mclk_i      (mclk_i),
        .srst_i      (srst_i),
        .ctl         (ctl.drv),
        .true_o      (true_clock_pin_o),
        .true_oe_n_o (true_clock_pin_oe_n_o),
        .comp_o      (complement_clock_pin_o),
        .comp_oe_n_o (complement_clock_pin_oe_n_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // All checks run on mclk_i and sleep through reset
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // A write reaching the register file
    sequence s_write(logic [7:0] off);
        wr_q && addr_q == off;
    endsequence

    // Registers leave reset at their reset values
    a_reset_values: assert property ($fell(srst_i) |->
        div_q == DIV_RST && mode_q == MODE_RST && amp_q == AMP_RST && en_q == EN_RST)
        else $error("register reset values wrong");

    // Ratio lands whole
    a_ratio_write: assert property (
        s_write(OFF_DIV) |=> div_q[13:0] == $past(hwdata_i[13:0]))
        else $error("divider ratio not stored");

    // Read-only reserved bits stay zero
    a_reserved_zero: assert property (
        !div_q[DIV_RSVD_BIT] && en_q[7:4] == 4'h0)
        else $error("read-only reserved bit set");

    // Reserved amplitude bits keep writes
    a_amp_reserved: assert property (
        s_write(OFF_AMP) |=> amp_q[2:0] == $past(hwdata_i[2:0]))
        else $error("reserved amplitude field not stored");

    // Software disable acts next cycle
    a_soft_disable: assert property (
        s_write(OFF_EN) ##0 hwdata_i[EN_DIS_BIT] |=> ctl.disabled)
        else $error("software disable not applied");

    // Reserved bits read back zero
    a_read_after: assert property (
        take && !hwrite_i && local_offset(haddr_i) == OFF_EN |=> hrdata_o[7:4] == 4'h0)
        else $error("reserved bits read non-zero");

    // Power-down floats both pins
    a_pd_pins: assert property (
        s_write(OFF_EN) ##0 hwdata_i[EN_PD_BIT] |=> ##1
        true_clock_pin_oe_n_o && complement_clock_pin_oe_n_o)
        else $error("power-down did not float pins");

    // Zero wait states, always OKAY
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or not OKAY");

    // Sub-word writes never reach a register
    a_size_refused: assert property (
        take && hwrite_i && hsize_i != HSIZE_WORD |=> !wr_q)
        else $error("sub-word write accepted");

    // Unmapped offsets read zero
    a_unmapped_zero: assert property (
        take && !hwrite_i && local_offset(haddr_i) == ADDR_NONE |=> hrdata_o == 32'h0)
        else $error("unmapped offset read non-zero");

    // Regulator bit follows software
    a_regulator_write: assert property (
        s_write(OFF_DIV) |=> divider_regulator_on_o == $past(hwdata_i[DIV_REG_ON_BIT]))
        else $error("regulator enable not stored");

    // Pins obey the enable logic again after power-down
    a_pd_release: assert property (
        $fell(ctl.pd) && !ctl.disabled |=> !true_clock_pin_oe_n_o)
        else $error("pins still floating after power-down");
endmodule
`default_nettype wire

/* File: testbench/clock_receiver_model.sv */
// Clock receiver on the two output pins: resolves each wire, times the true line.
// Assumes pins change on mclk_i only and the wires carry no pull resistor.
`default_nettype none
module clock_receiver_model (
    // Clock
    input  wire logic        mclk_i,
    // Pins from the stage
    input  wire logic        true_i,
    input  wire logic        true_oe_n_i,
    input  wire logic        comp_i,
    input  wire logic        comp_oe_n_i,
    // Levels seen at the receiver
    output logic             true_lvl_o,
    output logic             comp_lvl_o,
    output logic      [31:0] period_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt_q = 32'h0;
    logic        t_q   = 1'b0;
    logic        c_q   = 1'b0;
    // A released wire flips each cycle so a stale value can never pass as driven
    always @(posedge mclk_i) begin
        t_q <= true_oe_n_i ? ~t_q : true_i;
        c_q <= comp_oe_n_i ? ~c_q : comp_i;
    end
    // Period of the true line in mclk cycles, rising edge to rising edge
    always @(posedge mclk_i) begin
        cnt_q <= (!t_q && !true_oe_n_i && true_i) ? 32'h1 : cnt_q + 32'h1;
        if (!t_q && !true_oe_n_i && true_i) begin
            period_o <= cnt_q;
        end
    end
    assign true_lvl_o = t_q;
    assign comp_lvl_o = c_q;
endmodule
`default_nettype wire

/* File: testbench/clock_output_stage_control_tb.sv */
// Self-checking bench for the clock output stage: registers, divider and pins.
// Assumes the one AHB-Lite slave answers on hreadyout and a 50 MHz clock.
`default_nettype none
module clock_output_stage_control_tb;
    import clock_output_stage_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Signals
    // ----
    logic        mclk, srst, hsel, hwrite, pin_en, hrdy, hresp, t_pin, t_oe_n, c_pin;
    logic        c_oe_n, reg_on, pd, bias, term, amp_hi, t_lvl, c_lvl;
    logic [31:0] haddr, hwdata, hrdata, period;
    logic [1:0]  htrans, dtype, cm;
    logic [2:0]  hsize;
    logic [3:0]  swing;
    logic [6:0]  f;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cycles = 0;
    clock_output_stage_control clock_output_stage_control_i (
        .mclk_i(mclk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .out_enable_pin_i(pin_en),
        .true_clock_pin_o(t_pin), .true_clock_pin_oe_n_o(t_oe_n),
        .complement_clock_pin_o(c_pin), .complement_clock_pin_oe_n_o(c_oe_n),
        .divider_regulator_on_o(reg_on), .driver_power_down_o(pd), .driver_bias_on_o(bias),
        .hcsl_term_on_o(term), .driver_type_o(dtype), .lvds_common_level_o(cm),
        .hcsl_swing_o(swing), .lvds_amp_high_o(amp_hi));
    clock_receiver_model clock_receiver_model_i (
        .mclk_i(mclk), .true_i(t_pin), .true_oe_n_i(t_oe_n), .comp_i(c_pin),
        .comp_oe_n_i(c_oe_n), .true_lvl_o(t_lvl), .comp_lvl_o(c_lvl), .period_o(period));
    // ----
    // Clock, hang guard and shared tasks
    // ----
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Whole run is under a thousand cycles; far beyond that means a hang
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single word transfer; every signal held until hready is seen high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge mclk);
        while (hrdy !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hrdy !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        @(posedge mclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    // Pin summary: driving, true hi/lo, comp hi/lo, always same, always opposite
    task automatic watch(output logic [6:0] s);
        s = 7'h03;
        repeat (6) @(posedge mclk);
        repeat (40) begin
            @(posedge mclk);
            s = s | {~t_oe_n | ~c_oe_n, t_lvl, ~t_lvl, c_lvl, ~c_lvl, 2'h0};
            s[1] = s[1] & (t_lvl == c_lvl);
            s[0] = s[0] & (t_lvl != c_lvl);
        end
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        rd_chk(OFF_DIV, 32'h00008069);
        rd_chk(OFF_EN, 32'h00000000);
        rd_chk(OFF_MODE, 32'h0000006C);
        rd_chk(OFF_AMP, 32'h000000B4);
        chk({reg_on, pd, bias, term, dtype, cm, swing, amp_hi},
            {1'b1, 1'b0, 1'b1, 1'b1, 2'h0, 2'h2, 4'hB, 1'b0});
        $display("test reset done");
    endtask
    task automatic t_regs();
        wr(OFF_DIV, 32'hFFFFFFFF);
        rd_chk(OFF_DIV, {16'h0000, DIV_WMASK});
        wr(OFF_EN, 32'hFFFFFFFF);
        rd_chk(OFF_EN, 32'h0000000F);
        wr(OFF_AMP, 32'h0000007A);
        chk({swing, amp_hi}, {4'h7, 1'b1});
        hsize <= 3'h0;
        wr(OFF_AMP, 32'h00000000);
        hsize <= HSIZE_WORD;
        rd_chk(OFF_AMP, 32'h0000007A);
        wr(ADDR_NONE, 32'hFFFFFFFF);
        rd_chk(ADDR_NONE, 32'h00000000);
        chk({hresp, hrdy}, 32'h00000001);
        for (int k = 0; k < 4; k++) begin
            wr(OFF_MODE, {24'h000000, 2'h1, k[1:0], 2'h1, k[1:0]});
            chk({dtype, cm, term, bias}, {k[1:0], k[1:0], 2'h1});
        end
        $display("test regs done");
    endtask
    task automatic t_period();
        wr(OFF_EN, 32'h00000000);
        wr(OFF_MODE, 32'h0000006C);
        for (int r = 10; r < 14; r += 3) begin
            wr(OFF_DIV, r);
            wr(OFF_DIV, 32'h00008000 | r);
            repeat (40) @(posedge mclk);
            chk(period, r);
        end
        $display("test period done");
    endtask
    task automatic t_disable();
        logic [6:0] exp [4] = '{7'h56, 7'h59, 7'h00, 7'h7D};
        for (int k = 0; k < 4; k++) begin
            wr(OFF_EN, {28'h0000000, k[1:0], 2'h2});
            watch(f);
            chk(k == 2 ? f & 7'h40 : f, exp[k]);
        end
        wr(OFF_EN, 32'h00000000);
        watch(f);
        chk(f, 7'h7D);
        wr(OFF_MODE, 32'h0000006E);
        wr(OFF_EN, 32'h00000002);
        watch(f);
        chk(f, 7'h59);
        wr(OFF_MODE, 32'h0000006C);
        wr(OFF_EN, 32'h00000000);
        pin_en <= 1'b0;
        watch(f);
        chk(f, 7'h56);
        pin_en <= 1'b1;
        wr(OFF_EN, 32'h0000000D);
        watch(f);
        chk({f & 7'h40, pd}, {7'h00, 1'b1});
        wr(OFF_EN, 32'h00000000);
        watch(f);
        chk(f, 7'h7D);
        $display("test disable done");
    endtask
    task automatic t_cmos();
        logic [6:0] exp [4] = '{7'h7E, 7'h7D, 7'h74, 7'h5C};
        for (int k = 0; k < 4; k++) begin
            wr(OFF_MODE, {24'h000000, k[1:0], 6'h2F});
            watch(f);
            chk(f, exp[k]);
        end
        wr(OFF_MODE, 32'h0000006C);
        wr(OFF_DIV, 32'h0000000A);
        watch(f);
        chk({f, reg_on}, {7'h59, 1'b0});
        rd_chk(OFF_STATUS, 32'h00000005);
        $display("test cmos and regulator done");
    endtask
    initial begin
        srst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        pin_en = 1'b1;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_regs();
        t_period();
        t_disable();
        t_cmos();
        final_report();
    end
endmodule
`default_nettype wire
